// [hw/gpde_params.svh]
// Constants for the port D upper / port E pin block
`ifndef GPDE_PARAMS_SVH
`define GPDE_PARAMS_SVH

`define GPDE_ADDR_W          4
`define GPDE_OFF_PIN_D       4'h0
`define GPDE_OFF_LATCH_D     4'h1
`define GPDE_OFF_DIR_D       4'h2
`define GPDE_OFF_ANSEL_D     4'h3
`define GPDE_OFF_PIN_E       4'h4
`define GPDE_OFF_LATCH_E     4'h5
`define GPDE_OFF_DIR_E       4'h6
`define GPDE_OFF_ANSEL_E     4'h7
`define GPDE_OFF_SLEW        4'h8
`define GPDE_OFF_CTRL        4'h9

`define GPDE_RST_DIR_D       8'hff
`define GPDE_RST_ANSEL_D     8'hff
`define GPDE_RST_LATCH       8'h00
`define GPDE_RST_DIR_E       8'h07
`define GPDE_RST_ANSEL_E     8'h07
`define GPDE_RST_SLEW        8'h1f
`define GPDE_RST_CTRL        8'h80

`define GPDE_E_LOW_MASK      8'h07
`define GPDE_SLEW_MASK       8'h1f
`define GPDE_BIT_PULLUP_EN   7
`define GPDE_BIT_PULLUP_DIS  7
`define GPDE_BIT_PIN3        3
`define GPDE_BIT_D6          6
`define GPDE_BIT_D7          7

`endif

// [hw/gpde_pkg.sv]
// Types for the port D upper / port E pin block
package gpde_pkg;
   typedef logic [7:0] gpde_byte_t;
   // Pin owner for the two upper port D pins, highest priority first
   typedef enum logic [3:0] {
      GPDE_OWN_SERIAL = 4'h1,
      GPDE_OWN_PWM    = 4'h2,
      GPDE_OWN_LATCH  = 4'h4,
      GPDE_OWN_NONE   = 4'h8
   } gpde_owner_t;
endpackage

// [hw/gpde_port.sv]
// Port E pins and upper port D pins with register file
//
// Contract
// - Port E has three bidirectional low pins and one input-only fourth pin.
// - A low pin selected analog reads back as zero.
// - Direction bit one disables the pin driver, making it input.
// - Direction bit zero drives the pin from its latch bit.
// - Direction bits rule drivers even while analog is selected.
// - Latch register is addressable; reads return latch, not pin levels.
// - Power-on reset selects the three low pins as analog.
// - Reset-enable clear: fourth pin is plain digital input, no direction or latch.
// - Reset-enable set: fourth pin is active-low master clear input.
// - Small package: port E is only the fourth pin, with master clear disabled; the code still gives master clear to reset-enable there.
// - Direction bit 7 of port E enables a weak pull-up on the fourth pin.
// - Global disable zero allows enabled pull-ups; one kills all pull-ups except one forced on by master clear or low-voltage programming.
// - Power-on reset leaves all pull-ups disabled.
// - Master clear or low-voltage programming forces the fourth pin pull-up on.
// - Upper D pins output from latch regardless of analog; input off when analog.
// - Upper D pins carry PWM outputs three and four when enabled.
// - Pin 6 drives serial transmit even with direction bit set.
// - Synchronous mode: pin 6 is serial clock, pin 7 serial data, either way.
// - Highest-priority enabled output function owns the pin, analog or not.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "gpde_params.svh"

module gpde_port #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [`GPDE_ADDR_W-1:0] addr,
   input  wire logic [7:0]              wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [7:0]                   rdata,
   input  wire logic                    reset_pin_enable,
   input  wire logic                    low_volt_prog_enable,
   input  wire logic [2:0]              port_e_in,
   output logic [2:0]                   port_e_out,
   output logic [2:0]                   port_e_oe,
   input  wire logic                    input_only_pin,
   output logic                         pin3_pullup_on,
   output logic                         master_clear_in_n,
   output logic                         global_pullup_disable_n,
   input  wire logic [1:0]              port_d_in,
   output logic [1:0]                   port_d_out,
   output logic [1:0]                   port_d_oe,
   input  wire logic                    pwm1_out_c,
   input  wire logic                    pwm1_out_d,
   input  wire logic                    pwm1_c_en,
   input  wire logic                    pwm1_d_en,
   input  wire logic                    serial2_en,
   input  wire logic                    serial2_sync,
   input  wire logic                    serial2_tx,
   input  wire logic                    serial2_sync_clk,
   input  wire logic                    serial2_clk_master,
   input  wire logic                    serial2_sync_data,
   input  wire logic                    serial2_data_drive,
   output logic                         serial2_rx,
   output logic                         serial2_clk_in,
   output logic [7:0]                   slew_control
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   gpde_pkg::gpde_byte_t dir_reg_d;
   gpde_pkg::gpde_byte_t out_latch_d;
   gpde_pkg::gpde_byte_t analog_sel_d;
   gpde_pkg::gpde_byte_t dir_reg_e;
   gpde_pkg::gpde_byte_t out_latch_e;
   gpde_pkg::gpde_byte_t analog_sel_e;
   gpde_pkg::gpde_byte_t slew_reg;
   gpde_pkg::gpde_byte_t ctrl_reg;
   logic [2:0]           e_sync1_reg;
   logic [2:0]           e_sync2_reg;
   logic                 p3_sync1_reg;
   logic                 p3_sync2_reg;
   logic [1:0]           d_sync1_reg;
   logic [1:0]           d_sync2_reg;
   logic                 low_present;

   // Small package has no low pins at all
   assign low_present = !SMALL_PACKAGE;

   function automatic logic wr_hit(input logic [`GPDE_ADDR_W-1:0] off);
      wr_hit = wr && (addr == off);
   endfunction

   // Port D upper direction
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir_reg_d <= `GPDE_RST_DIR_D;
      end else if (wr_hit(`GPDE_OFF_DIR_D)) begin
         dir_reg_d <= wdata;
      end
   end

   // Port D latch: writing the pin register also lands in the latch
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_latch_d <= `GPDE_RST_LATCH;
      end else if (wr_hit(`GPDE_OFF_LATCH_D) || wr_hit(`GPDE_OFF_PIN_D)) begin
         out_latch_d <= wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analog_sel_d <= `GPDE_RST_ANSEL_D;
      end else if (wr_hit(`GPDE_OFF_ANSEL_D)) begin
         analog_sel_d <= wdata;
      end
   end

   // Port E direction; bit 7 is the fourth pin pull-up enable
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dir_reg_e <= `GPDE_RST_DIR_E;
      end else if (wr_hit(`GPDE_OFF_DIR_E)) begin
         dir_reg_e <= wdata & (`GPDE_E_LOW_MASK | (8'h01 << `GPDE_BIT_PULLUP_EN));
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         out_latch_e <= `GPDE_RST_LATCH;
      end else if (wr_hit(`GPDE_OFF_LATCH_E) || wr_hit(`GPDE_OFF_PIN_E)) begin
         out_latch_e <= wdata & `GPDE_E_LOW_MASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analog_sel_e <= `GPDE_RST_ANSEL_E;
      end else if (wr_hit(`GPDE_OFF_ANSEL_E)) begin
         analog_sel_e <= wdata & `GPDE_E_LOW_MASK;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         slew_reg <= `GPDE_RST_SLEW;
      end else if (wr_hit(`GPDE_OFF_SLEW)) begin
         slew_reg <= wdata & `GPDE_SLEW_MASK;
      end
   end

   // Bit 7 is the global pull-up disable, set after reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_reg <= `GPDE_RST_CTRL;
      end else if (wr_hit(`GPDE_OFF_CTRL)) begin
         ctrl_reg <= wdata & (8'h01 << `GPDE_BIT_PULLUP_DIS);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         e_sync1_reg  <= 3'h0;
         e_sync2_reg  <= 3'h0;
         p3_sync1_reg <= 1'b0;
         p3_sync2_reg <= 1'b0;
         d_sync1_reg  <= 2'h0;
         d_sync2_reg  <= 2'h0;
      end else begin
         e_sync1_reg  <= port_e_in;
         e_sync2_reg  <= e_sync1_reg;
         p3_sync1_reg <= input_only_pin;
         p3_sync2_reg <= p3_sync1_reg;
         d_sync1_reg  <= port_d_in;
         d_sync2_reg  <= d_sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port E pins

   logic [2:0] e_dig_in;
   logic       p3_port_mode;

   // Analog pins read zero; direction still rules the driver
   assign e_dig_in   = e_sync2_reg & ~analog_sel_e[2:0] & {3{low_present}};
   assign port_e_oe  = ~dir_reg_e[2:0] & {3{low_present}};
   assign port_e_out = out_latch_e[2:0] & {3{low_present}};

   // Fourth pin is port input or master clear, never driven
   assign p3_port_mode      = !reset_pin_enable;
   assign master_clear_in_n = reset_pin_enable ? input_only_pin : 1'b1;

   // Programming and reset uses force the pull-up past the enable bits
   assign pin3_pullup_on = reset_pin_enable || low_volt_prog_enable ||
                           (!ctrl_reg[`GPDE_BIT_PULLUP_DIS] &&
                            dir_reg_e[`GPDE_BIT_PULLUP_EN]);
   assign global_pullup_disable_n = !ctrl_reg[`GPDE_BIT_PULLUP_DIS];

   ////////////////////////////////////////////////////////////////////////////
   // Port D upper pins

   gpde_pkg::gpde_owner_t own6;
   gpde_pkg::gpde_owner_t own7;
   logic [1:0]            d_dig_in;

   // Serial beats PWM beats latch; analog select does not block outputs
   always_comb begin
      own6 = gpde_pkg::GPDE_OWN_NONE;
      own7 = gpde_pkg::GPDE_OWN_NONE;
      if (serial2_en && (!serial2_sync || serial2_clk_master)) begin
         own6 = gpde_pkg::GPDE_OWN_SERIAL;
      end else if (!dir_reg_d[`GPDE_BIT_D6]) begin
         own6 = pwm1_c_en ? gpde_pkg::GPDE_OWN_PWM : gpde_pkg::GPDE_OWN_LATCH;
      end
      if (serial2_en && serial2_sync && serial2_data_drive) begin
         own7 = gpde_pkg::GPDE_OWN_SERIAL;
      end else if (!dir_reg_d[`GPDE_BIT_D7]) begin
         own7 = pwm1_d_en ? gpde_pkg::GPDE_OWN_PWM : gpde_pkg::GPDE_OWN_LATCH;
      end
   end

   always_comb begin
      port_d_out = 2'h0;
      case (own6)
         gpde_pkg::GPDE_OWN_SERIAL: begin
            port_d_out[0] = serial2_sync ? serial2_sync_clk : serial2_tx;
         end
         gpde_pkg::GPDE_OWN_PWM: begin
            port_d_out[0] = pwm1_out_c;
         end
         gpde_pkg::GPDE_OWN_LATCH: begin
            port_d_out[0] = out_latch_d[`GPDE_BIT_D6];
         end
         default: begin
            port_d_out[0] = 1'b0;
         end
      endcase
      case (own7)
         gpde_pkg::GPDE_OWN_SERIAL: begin
            port_d_out[1] = serial2_sync_data;
         end
         gpde_pkg::GPDE_OWN_PWM: begin
            port_d_out[1] = pwm1_out_d;
         end
         gpde_pkg::GPDE_OWN_LATCH: begin
            port_d_out[1] = out_latch_d[`GPDE_BIT_D7];
         end
         default: begin
            port_d_out[1] = 1'b0;
         end
      endcase
   end

   assign port_d_oe[0] = (own6 != gpde_pkg::GPDE_OWN_NONE);
   assign port_d_oe[1] = (own7 != gpde_pkg::GPDE_OWN_NONE);

   // Digital input path is cut while analog is selected
   assign d_dig_in       = d_sync2_reg & ~analog_sel_d[7:6];
   assign serial2_rx     = d_dig_in[1];
   assign serial2_clk_in = d_dig_in[0];
   assign slew_control   = slew_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data one cycle after the strobe, zero otherwise

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (!rd) begin
         rdata <= 8'h00;
      end else begin
         case (addr)
            `GPDE_OFF_PIN_D:   rdata <= {d_dig_in, 6'h00};
            `GPDE_OFF_LATCH_D: rdata <= out_latch_d;
            `GPDE_OFF_DIR_D:   rdata <= dir_reg_d;
            `GPDE_OFF_ANSEL_D: rdata <= analog_sel_d;
            `GPDE_OFF_PIN_E:   rdata <= {4'h0, p3_sync2_reg & p3_port_mode, e_dig_in};
            `GPDE_OFF_LATCH_E: rdata <= out_latch_e;
            `GPDE_OFF_DIR_E:   rdata <= dir_reg_e;
            `GPDE_OFF_ANSEL_E: rdata <= analog_sel_e;
            `GPDE_OFF_SLEW:    rdata <= slew_reg;
            `GPDE_OFF_CTRL:    rdata <= ctrl_reg;
            default:           rdata <= 8'h00;
         endcase
      end
   end

endmodule

// [tb/gpde_port_properties.sv]
// Port pin block assertions
`timescale 1ns/1ps
`include "gpde_params.svh"
module gpde_port_props (
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire logic [`GPDE_ADDR_W-1:0] addr,
   input wire logic [7:0]              wdata,
   input wire logic                    wr,
   input wire logic                    rd,
   input wire logic [7:0]              rdata,
   input wire logic                    reset_pin_enable,
   input wire logic                    low_volt_prog_enable,
   input wire logic                    input_only_pin,
   input wire logic                    pin3_pullup_on,
   input wire logic                    master_clear_in_n,
   input wire logic                    global_pullup_disable_n,
   input wire logic [2:0]              port_e_out,
   input wire logic [2:0]              port_e_oe,
   input wire logic [1:0]              port_d_out,
   input wire logic [1:0]              port_d_oe,
   input wire logic                    serial2_en,
   input wire logic                    serial2_sync,
   input wire logic                    serial2_tx
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_wr(logic [`GPDE_ADDR_W-1:0] a);
      wr && addr == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_dir_drives: assert property (s_wr(`GPDE_OFF_DIR_E) |=>
      port_e_oe == ~$past(wdata[2:0])) else $error("Enable not from direction");
   a_latch_drives: assert property (s_wr(`GPDE_OFF_LATCH_E) |=>
      port_e_out == $past(wdata[2:0])) else $error("Drive not from latch");
   a_read_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("Read data outside read cycle");
   a_master_clear_in_follow: assert property (reset_pin_enable |->
      master_clear_in_n == input_only_pin) else $error("Clear input not from pin");
   a_port_pin_mode: assert property (!reset_pin_enable |-> master_clear_in_n)
      else $error("Clear asserted in port mode");
   a_pullup_forced: assert property ((reset_pin_enable || low_volt_prog_enable)
      |-> pin3_pullup_on) else $error("Pull-up not forced");
   a_global_off: assert property ((!global_pullup_disable_n && !reset_pin_enable
      && !low_volt_prog_enable) |-> !pin3_pullup_on) else $error("Pull-up not disabled");
   a_global_write: assert property (s_wr(`GPDE_OFF_CTRL) |=>
      global_pullup_disable_n == !$past(wdata[7])) else $error("Global pull-up bit");
   a_tx_owns_d6: assert property ((serial2_en && !serial2_sync) |->
      port_d_oe[0] && port_d_out[0] == serial2_tx) else $error("Transmit not on pin 6");
endmodule

bind gpde_port gpde_port_props u_props (.*);

// [tb/gpde_board.sv]
// Board circuitry on the port pins
`timescale 1ns/1ps
module gpde_board (
   input wire logic [2:0] port_e_out,
   input wire logic [2:0] port_e_oe,
   input wire logic [1:0] port_d_out,
   input wire logic [1:0] port_d_oe,
   input wire logic       pin3_pullup_on,
   input wire logic [2:0] ext_e,
   input wire logic [1:0] ext_d,
   input wire logic       ext3,
   input wire logic       ext3_drive,
   output logic [2:0]     port_e_in,
   output logic [1:0]     port_d_in,
   output logic           input_only_pin
);
   // A pin follows the chip where it drives, else the board level
   assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & ext_e);
   assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & ext_d);
   // Undriven fourth pin floats; only the weak pull-up makes it defined
   assign input_only_pin = ext3_drive ? ext3 : (pin3_pullup_on ? 1'h1 : ~ext3);
endmodule

// [tb/tb_gpde_port.sv]
// Testbench for the port pin block
`timescale 1ns/1ps
`include "gpde_params.svh"
module tb_gpde_port;
   logic clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0, ext3 = 1'h1, ext3_drive = 1'h1;
   logic [`GPDE_ADDR_W-1:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, slew_control;
   logic reset_pin_enable = 1'h0, low_volt_prog_enable = 1'h0, pwm1_out_c = 1'h0;
   logic pwm1_out_d = 1'h0, pwm1_c_en = 1'h0, pwm1_d_en = 1'h0, serial2_en = 1'h0;
   logic serial2_sync = 1'h0, serial2_tx = 1'h0, serial2_sync_clk = 1'h0;
   logic serial2_clk_master = 1'h0, serial2_sync_data = 1'h0, serial2_data_drive = 1'h0;
   logic [2:0] port_e_in, port_e_out, port_e_oe, ext_e = 3'h2;
   logic [1:0] port_d_in, port_d_out, port_d_oe, ext_d = 2'h0;
   logic input_only_pin, pin3_pullup_on, master_clear_in_n, global_pullup_disable_n;
   logic serial2_rx, serial2_clk_in;
   int n_mismatch = 0, compares = 0;
   gpde_port DUT (.*);
   gpde_board u_board (.*);
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr_reg(logic [3:0] a, logic [7:0] d);
      @(posedge clk) begin wr <= 1'h1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'h0;
      #1;
   endtask
   task automatic rd_chk(logic [3:0] a, logic [7:0] exp, string name);
      @(posedge clk) begin rd <= 1'h1; addr <= a; end
      @(posedge clk) rd <= 1'h0;
      #1 chk(name, exp, rdata);
   endtask
   task automatic step;
      @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_chk(`GPDE_OFF_ANSEL_E, 8'h07, "analog_e");
      rd_chk(`GPDE_OFF_CTRL, 8'h80, "ctrl");
      chk("pullup", 8'h00, {7'h00, pin3_pullup_on});
      chk("slew", 8'h1f, slew_control);
      rd_chk(`GPDE_OFF_SLEW, 8'h1f, "slew_reg");
      chk("oe_e", {5'h00, port_e_oe}, 8'h00);
      rd_chk(4'hf, 8'h00, "unmapped");
      $display("t_reset done");
   endtask
   task automatic t_drive;
      wr_reg(`GPDE_OFF_LATCH_E, 8'h05);
      wr_reg(`GPDE_OFF_DIR_E, 8'h02);
      chk("oe_e", {5'h00, port_e_oe}, 8'h05);
      chk("out_e", {5'h00, port_e_out}, 8'h05);
      rd_chk(`GPDE_OFF_LATCH_E, 8'h05, "latch_e");
      wr_reg(`GPDE_OFF_DIR_E, 8'hff);
      rd_chk(`GPDE_OFF_DIR_E, 8'h87, "dir_e");
      chk("oe_e", {5'h00, port_e_oe}, 8'h00);
      rd_chk(`GPDE_OFF_PIN_E, 8'h08, "pin_e_analog");
      wr_reg(`GPDE_OFF_ANSEL_E, 8'h00);
      step();
      rd_chk(`GPDE_OFF_PIN_E, 8'h0a, "pin_e");
      $display("t_drive done");
   endtask
   task automatic t_pullup;
      wr_reg(`GPDE_OFF_CTRL, 8'h00);
      chk("pullup_on", 8'h01, {7'h00, pin3_pullup_on});
      wr_reg(`GPDE_OFF_DIR_E, 8'h07);
      chk("pullup_off", 8'h00, {7'h00, pin3_pullup_on});
      wr_reg(`GPDE_OFF_CTRL, 8'h80);
      @(posedge clk) begin reset_pin_enable <= 1'h1; ext3 <= 1'h0; end
      step();
      chk("forced", 8'h02, {6'h00, pin3_pullup_on, master_clear_in_n});
      rd_chk(`GPDE_OFF_PIN_E, 8'h02, "pin_e_clear");
      @(posedge clk) begin reset_pin_enable <= 1'h0; low_volt_prog_enable <= 1'h1; end
      step();
      chk("lvp", 8'h01, {7'h00, pin3_pullup_on});
      @(posedge clk) low_volt_prog_enable <= 1'h0;
      $display("t_pullup done");
   endtask
   task automatic t_port_d;
      wr_reg(`GPDE_OFF_DIR_D, 8'h3f);
      wr_reg(`GPDE_OFF_LATCH_D, 8'h40);
      chk("d_latch", 8'h0d, {4'h0, port_d_oe, port_d_out});
      @(posedge clk) begin pwm1_c_en <= 1'h1; pwm1_d_en <= 1'h1; pwm1_out_d <= 1'h1; end
      step();
      chk("d_pwm", 8'h0e, {4'h0, port_d_oe, port_d_out});
      wr_reg(`GPDE_OFF_DIR_D, 8'hff);
      @(posedge clk) begin serial2_en <= 1'h1; serial2_tx <= 1'h1; end
      step();
      chk("d_tx", 8'h03, {6'h00, port_d_oe[0], port_d_out[0]});
      @(posedge clk) begin serial2_sync <= 1'h1; serial2_clk_master <= 1'h1; end
      @(posedge clk) begin serial2_data_drive <= 1'h1; serial2_sync_data <= 1'h1; end
      step();
      chk("d_sync", 8'h0e, {4'h0, port_d_oe, port_d_out});
      rd_chk(`GPDE_OFF_PIN_D, 8'h00, "pin_d_analog");
      wr_reg(`GPDE_OFF_ANSEL_D, 8'h00);
      rd_chk(`GPDE_OFF_PIN_D, 8'h80, "pin_d");
      chk("rx", 8'h01, {7'h00, serial2_rx});
      chk("clk_in", 8'h00, {7'h00, serial2_clk_in});
      $display("t_port_d done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'h1;
      t_reset();
      t_drive();
      t_pullup();
      t_port_d();
      tally_and_finish();
   end
   // Tests need about 60 cycles; allow twenty-five times that
   initial begin
      #12000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
